/* File: adc_par_pkg.sv */
// shared constants and types of the converter port and its host controller
package adc_par_pkg;
  // ****************************************
  // clock and widths
  // ****************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int RESULT_W      = 10;
  localparam int BYTE_W        = 8;
  localparam int HIGH_W        = RESULT_W - BYTE_W;
  localparam int CH_W          = 3;
  localparam int BIDX_W        = 4;
  localparam int CNT_W         = 8;
  localparam logic [BIDX_W-1:0] MSB_IDX = 4'h9;
  // ****************************************
  // control byte layout
  // ****************************************
  localparam int CTRL_CH_LSB     = 0;
  localparam int CTRL_SGL_BIT    = 3;
  localparam int CTRL_UNI_BIT    = 4;
  localparam int CTRL_ACQ_BIT    = 5;
  localparam int CTRL_PD_LSB     = 6;
  localparam logic [1:0] PD_EXT_CLK = 2'h3;
  // ****************************************
  // converter timing: sequence lengths in converter clock ticks, internal tick from acquisition time
  // ****************************************
  localparam logic [CNT_W-1:0] ACQ_TICKS  = 8'h03;
  localparam logic [CNT_W-1:0] CONV_TICKS = 8'h0d;
  localparam int INT_ACQ_TIME_NS = 1000;
  localparam int INT_TICK_CYCLES = INT_ACQ_TIME_NS / (3 * CLK_PERIOD_NS);
  // ****************************************
  // host pin timing, least times rounded up
  // ****************************************
  localparam int CS_SETUP_NS = 60;
  localparam int WR_PULSE_NS = 60;
  localparam int RD_DATA_NS  = 110;
  localparam int CS_SETUP_CYC = (CS_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_PULSE_CYC = (WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RD_WAIT_CYC  = (RD_DATA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ****************************************
  // host controller registers
  // ****************************************
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL_WRITE = 8'h00;
  localparam logic [ADDR_W-1:0] REG_READ_START = 8'h04;
  localparam logic [ADDR_W-1:0] REG_STATUS     = 8'h08;
  localparam logic [ADDR_W-1:0] REG_RESULT     = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_CLK_CFG    = 8'h10;
  // ****************************************
  // state encodings
  // ****************************************
  typedef enum logic [1:0] {
    D_IDLE = 2'h0, D_ACQ_INT = 2'h1, D_CONV = 2'h3, D_ACQ_EXT = 2'h2
  } dev_state_e;
  typedef enum logic [1:0] {
    H_IDLE = 2'h0, H_SETUP = 2'h1, H_STROBE = 2'h3, H_HOLD = 2'h2
  } host_state_e;
endpackage

/* File: adc_par_if.sv */
// pins between the converter and its host, with wire resolution
interface adc_par_if;
  logic       cs_n;
  logic       wr_n;
  logic       rd_n;
  logic       upper_byte_select;
  logic       conv_clk;
  logic [7:0] host_data;
  logic       host_data_oe;
  logic [7:0] dev_data;
  logic       dev_data_oe;
  logic       dev_done_n;
  logic       dev_done_oe;
  logic [7:0] data_bus_lines;
  logic       done_line_n;
  // undriven lines read high, as through a pull-up
  assign data_bus_lines = dev_data_oe ? dev_data : (host_data_oe ? host_data : 8'hff);
  assign done_line_n    = dev_done_oe ? dev_done_n : 1'b1;
  modport dev (
    input  cs_n, wr_n, rd_n, upper_byte_select, conv_clk, data_bus_lines,
    output dev_data, dev_data_oe, dev_done_n, dev_done_oe
  );
  modport host (
    input  data_bus_lines, done_line_n,
    output cs_n, wr_n, rd_n, upper_byte_select, conv_clk, host_data, host_data_oe
  );
endinterface

/* File: adc_par_dev.sv */
// converter end: control byte capture, sequencing, search and readout
// Behaviour
// - done line low when result ready
// - read strobe fall with select low drives data
// - internal acquisition: write starts acquire then convert
// - external acquisition: next write starts conversion
// - host gives clock pin or ties it
// - select high floats done and data
// - single-ended: channel to positive, common to negative
// - pseudo-differential: channel pair, positive sampled
// - track during acquisition, hold at end
// - conversion starts by switching to negative input
// - ten bit search, msb first
// - result split as low byte plus two bits
// - upper select picks two msbs on low lines
// - done line high on read or write
// - thirteen clock conversion; write aborts it
//
// The implementer's own choices: the plain strobed port and the address map.
module adc_par_dev #(
  parameter int NUM_CH    = 8,
  parameter int TICK_DIV  = adc_par_pkg::INT_TICK_CYCLES
) (
  input  wire logic                               ref_clk,
  input  wire logic                               rstn,
  adc_par_if.dev                                  pins,
  input  wire logic                               comparator_high,
  output logic                                    track,
  output logic                                    hold_to_negative,
  output logic [adc_par_pkg::CH_W-1:0]            pos_channel,
  output logic [adc_par_pkg::CH_W-1:0]            neg_channel,
  output logic                                    neg_is_common,
  output logic                                    unipolar,
  output logic [adc_par_pkg::RESULT_W-1:0]        dac_code
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    adc_par_pkg::dev_state_e                st;
    logic                                   wr_q;
    logic                                   rd_q;
    logic                                   clk_q;
    logic [adc_par_pkg::BYTE_W-1:0]         wdata;
    logic [adc_par_pkg::BYTE_W-1:0]         ctrl;
    logic [adc_par_pkg::CNT_W-1:0]          ticks;
    logic [15:0]                            div;
    logic [adc_par_pkg::BIDX_W-1:0]         bidx;
    logic                                   searching;
    logic [adc_par_pkg::RESULT_W-1:0]       sar;
    logic [adc_par_pkg::RESULT_W-1:0]       result;
    logic                                   done_n;
    logic                                   driving;
    logic [adc_par_pkg::BYTE_W-1:0]         dout;
    logic                                   dout_oe;
    logic                                   done_oe;
    logic                                   track;
    logic                                   to_neg;
    logic [adc_par_pkg::CH_W-1:0]           pos;
    logic [adc_par_pkg::CH_W-1:0]           neg;
    logic                                   neg_com;
  } dev_s;

  dev_s s_reg;
  dev_s s_next;

  localparam logic [15:0] TICK_LAST = 16'(TICK_DIV - 1);
  localparam logic [adc_par_pkg::CH_W-1:0] CH_MASK = adc_par_pkg::CH_W'(NUM_CH - 1);

  logic                               wr_rise;
  logic                               rd_fall;
  logic                               tick;
  logic [adc_par_pkg::CH_W-1:0]       new_ch;
  logic [adc_par_pkg::BYTE_W-1:0]     wbyte;

  always_comb begin
    s_next = s_reg;
    wr_rise = !pins.cs_n && !s_reg.wr_q && pins.wr_n;
    rd_fall = !pins.cs_n && s_reg.rd_q && !pins.rd_n;
    wbyte = s_reg.wdata;
    new_ch = wbyte[adc_par_pkg::CTRL_CH_LSB +: adc_par_pkg::CH_W] & CH_MASK;
    // ****************************************
    // pin sampling and converter clock tick
    // ****************************************
    s_next.wr_q = pins.wr_n;
    s_next.rd_q = pins.rd_n;
    s_next.clk_q = pins.conv_clk;
    if (!pins.cs_n && !pins.wr_n) begin
      s_next.wdata = pins.data_bus_lines;
    end
    // a clock pin tied static gives no ticks, so external mode just stalls
    if (s_reg.ctrl[adc_par_pkg::CTRL_PD_LSB +: 2] == adc_par_pkg::PD_EXT_CLK) begin
      tick = s_reg.clk_q && !pins.conv_clk;
    end else begin
      tick = (s_reg.div == TICK_LAST);
    end
    s_next.div = (s_reg.div == TICK_LAST) ? 16'h0000 : s_reg.div + 16'h0001;
    if (tick) begin
      s_next.ticks = s_reg.ticks + 8'h01;
    end
    // ****************************************
    // acquisition and conversion sequence
    // ****************************************
    case (s_reg.st)
      adc_par_pkg::D_ACQ_INT: begin
        if (tick && s_reg.ticks == adc_par_pkg::ACQ_TICKS - 8'h01) begin
          s_next.st = adc_par_pkg::D_CONV;
          s_next.ticks = 8'h00;
          s_next.track = 1'b0;
        end
      end
      adc_par_pkg::D_CONV: begin
        if (tick) begin
          if (s_reg.ticks == 8'h00) begin
            s_next.to_neg = 1'b1;
            s_next.searching = 1'b1;
            s_next.bidx = adc_par_pkg::MSB_IDX;
            s_next.sar = 10'h200;
          end else if (s_reg.searching) begin
            // decide the trial bit, then try the next lower one
            s_next.sar[s_reg.bidx] = comparator_high;
            if (s_reg.bidx == 4'h0) begin
              s_next.searching = 1'b0;
            end else begin
              s_next.bidx = s_reg.bidx - 4'h1;
              s_next.sar[s_reg.bidx - 4'h1] = 1'b1;
            end
          end
          if (s_reg.ticks == adc_par_pkg::CONV_TICKS - 8'h01) begin
            s_next.st = adc_par_pkg::D_IDLE;
            s_next.result = s_reg.sar;
            s_next.to_neg = 1'b0;
          end
        end
      end
      adc_par_pkg::D_ACQ_EXT, adc_par_pkg::D_IDLE: begin
      end
      default: begin
        s_next.st = adc_par_pkg::D_IDLE;
      end
    endcase
    // ****************************************
    // control byte write
    // ****************************************
    if (wr_rise) begin
      s_next.ticks = 8'h00;
      s_next.div = 16'h0000;
      s_next.searching = 1'b0;
      s_next.to_neg = 1'b0;
      s_next.done_n = 1'b1;
      if (s_reg.st == adc_par_pkg::D_ACQ_EXT && !wbyte[adc_par_pkg::CTRL_ACQ_BIT]) begin
        // channel bits must match the first write; power bits may change
        s_next.ctrl[adc_par_pkg::CTRL_PD_LSB +: 2] = wbyte[adc_par_pkg::CTRL_PD_LSB +: 2];
        s_next.st = adc_par_pkg::D_CONV;
        s_next.track = 1'b0;
      end else begin
        // also the abort path of a write landing mid-conversion
        s_next.ctrl = wbyte;
        s_next.st = wbyte[adc_par_pkg::CTRL_ACQ_BIT] ? adc_par_pkg::D_ACQ_EXT
                                                      : adc_par_pkg::D_ACQ_INT;
        s_next.track = 1'b1;
        if (wbyte[adc_par_pkg::CTRL_SGL_BIT]) begin
          s_next.pos = new_ch;
          s_next.neg = new_ch;
          s_next.neg_com = 1'b1;
        end else begin
          // pairs are neighbouring channels; the low bit picks the polarity
          s_next.pos = new_ch;
          s_next.neg = new_ch ^ 3'h1;
          s_next.neg_com = 1'b0;
        end
      end
    end
    // ****************************************
    // readout and done line
    // ****************************************
    if (rd_fall) begin
      s_next.done_n = 1'b1;
      s_next.driving = 1'b1;
    end
    if (pins.cs_n || pins.rd_n) begin
      s_next.driving = 1'b0;
    end
    // completion wins over a read landing in the same cycle
    if (s_reg.st == adc_par_pkg::D_CONV && s_next.st == adc_par_pkg::D_IDLE) begin
      s_next.done_n = 1'b0;
    end
    s_next.dout_oe = !pins.cs_n && !pins.rd_n && (s_reg.driving || rd_fall);
    s_next.done_oe = !pins.cs_n;
    if (pins.upper_byte_select) begin
      s_next.dout = {6'h00, s_reg.result[adc_par_pkg::RESULT_W-1 -: adc_par_pkg::HIGH_W]};
    end else begin
      s_next.dout = s_reg.result[adc_par_pkg::BYTE_W-1:0];
    end
    if (!rstn) begin
      s_next = '0;
      s_next.wr_q = 1'b1;
      s_next.rd_q = 1'b1;
      s_next.done_n = 1'b1;
      s_next.st = adc_par_pkg::D_IDLE;
    end
  end

  always_ff @(posedge ref_clk) begin
    s_reg <= s_next;
  end

  // ****************************************
  // outputs
  // ****************************************
  assign pins.dev_data    = s_reg.dout;
  assign pins.dev_data_oe = s_reg.dout_oe;
  assign pins.dev_done_n  = s_reg.done_n;
  assign pins.dev_done_oe = s_reg.done_oe;
  assign track            = s_reg.track;
  assign hold_to_negative = s_reg.to_neg;
  assign pos_channel      = s_reg.pos;
  assign neg_channel      = s_reg.neg;
  assign neg_is_common    = s_reg.neg_com;
  assign unipolar         = s_reg.ctrl[adc_par_pkg::CTRL_UNI_BIT];
  assign dac_code         = s_reg.sar;
endmodule

/* File: adc_par_host.sv */
// host end: register-driven write and two-part read cycles on the pins
module adc_par_host #(
  parameter int EXT_CLK_HALF = 26
) (
  input  wire logic                              ref_clk,
  input  wire logic                              rstn,
  adc_par_if.host                                pins,
  input  wire logic [adc_par_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic [31:0]                       reg_wdata,
  input  wire logic                              reg_wr,
  input  wire logic                              reg_rd,
  output logic [31:0]                            reg_rdata
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    adc_par_pkg::host_state_e             st;
    logic [7:0]                           cnt;
    logic                                 is_read;
    logic                                 upper;
    logic [adc_par_pkg::BYTE_W-1:0]       low;
    logic [adc_par_pkg::RESULT_W-1:0]     result;
    logic                                 valid;
    logic                                 ext_clk;
    logic [7:0]                           div;
    logic                                 clk;
    logic                                 cs_n;
    logic                                 wr_n;
    logic                                 rd_n;
    logic                                 upper_sel;
    logic [adc_par_pkg::BYTE_W-1:0]       data;
    logic                                 data_oe;
    logic [31:0]                          rdata;
  } host_s;

  host_s h_reg;
  host_s h_next;

  localparam logic [7:0] SETUP_LAST = 8'(adc_par_pkg::CS_SETUP_CYC - 1);
  localparam logic [7:0] WR_LAST    = 8'(adc_par_pkg::WR_PULSE_CYC - 1);
  localparam logic [7:0] RD_LAST    = 8'(adc_par_pkg::RD_WAIT_CYC - 1);
  localparam logic [7:0] HALF_LAST  = 8'(EXT_CLK_HALF - 1);

  always_comb begin
    h_next = h_reg;
    h_next.cnt = h_reg.cnt + 8'h01;
    // ****************************************
    // clock pin: free divider or tied low
    // ****************************************
    h_next.div = (h_reg.div == HALF_LAST) ? 8'h00 : h_reg.div + 8'h01;
    if (!h_reg.ext_clk) begin
      h_next.clk = 1'b0;
    end else if (h_reg.div == HALF_LAST) begin
      h_next.clk = !h_reg.clk;
    end
    // ****************************************
    // pin sequence
    // ****************************************
    case (h_reg.st)
      adc_par_pkg::H_IDLE: begin
        // write and read-start commands are ignored while a cycle runs
        if (reg_wr && reg_addr == adc_par_pkg::REG_CTRL_WRITE) begin
          h_next.st = adc_par_pkg::H_SETUP;
          h_next.is_read = 1'b0;
          h_next.data = reg_wdata[7:0];
          h_next.data_oe = 1'b1;
          h_next.cs_n = 1'b0;
          h_next.cnt = 8'h00;
        end else if (reg_wr && reg_addr == adc_par_pkg::REG_READ_START) begin
          h_next.st = adc_par_pkg::H_SETUP;
          h_next.is_read = 1'b1;
          h_next.upper = 1'b0;
          h_next.upper_sel = 1'b0;
          h_next.valid = 1'b0;
          h_next.cs_n = 1'b0;
          h_next.cnt = 8'h00;
        end
      end
      adc_par_pkg::H_SETUP: begin
        if (h_reg.cnt == SETUP_LAST) begin
          h_next.st = adc_par_pkg::H_STROBE;
          h_next.cnt = 8'h00;
          h_next.wr_n = h_reg.is_read;
          h_next.rd_n = !h_reg.is_read;
        end
      end
      adc_par_pkg::H_STROBE: begin
        if (!h_reg.is_read && h_reg.cnt == WR_LAST) begin
          h_next.st = adc_par_pkg::H_HOLD;
          h_next.wr_n = 1'b1;
        end else if (h_reg.is_read && h_reg.cnt == RD_LAST) begin
          h_next.st = adc_par_pkg::H_HOLD;
          h_next.rd_n = 1'b1;
          if (h_reg.upper) begin
            h_next.result = {pins.data_bus_lines[adc_par_pkg::HIGH_W-1:0], h_reg.low};
            h_next.valid = 1'b1;
          end else begin
            h_next.low = pins.data_bus_lines;
          end
        end
      end
      adc_par_pkg::H_HOLD: begin
        h_next.cnt = 8'h00;
        if (h_reg.is_read && !h_reg.upper) begin
          // second half keeps select low, swaps the byte select and drops the read strobe again
          h_next.st = adc_par_pkg::H_STROBE;
          h_next.upper = 1'b1;
          h_next.upper_sel = 1'b1;
          h_next.rd_n = 1'b0;
        end else begin
          h_next.st = adc_par_pkg::H_IDLE;
          h_next.cs_n = 1'b1;
          h_next.data_oe = 1'b0;
          h_next.upper_sel = 1'b0;
        end
      end
      default: begin
        h_next.st = adc_par_pkg::H_IDLE;
      end
    endcase
    // ****************************************
    // software registers
    // ****************************************
    if (reg_wr && reg_addr == adc_par_pkg::REG_CLK_CFG) begin
      h_next.ext_clk = reg_wdata[0];
    end
    h_next.rdata = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        adc_par_pkg::REG_STATUS:
          h_next.rdata = {29'h0, !pins.done_line_n, h_reg.valid, h_reg.st != adc_par_pkg::H_IDLE};
        adc_par_pkg::REG_RESULT:  h_next.rdata = {22'h0, h_reg.result};
        adc_par_pkg::REG_CLK_CFG: h_next.rdata = {31'h0, h_reg.ext_clk};
        default:                  h_next.rdata = 32'h0000_0000;
      endcase
    end
    if (!rstn) begin
      h_next = '0;
      h_next.st = adc_par_pkg::H_IDLE;
      h_next.cs_n = 1'b1;
      h_next.wr_n = 1'b1;
      h_next.rd_n = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    h_reg <= h_next;
  end

  assign pins.cs_n              = h_reg.cs_n;
  assign pins.wr_n              = h_reg.wr_n;
  assign pins.rd_n              = h_reg.rd_n;
  assign pins.upper_byte_select = h_reg.upper_sel;
  assign pins.conv_clk          = h_reg.clk;
  assign pins.host_data         = h_reg.data;
  assign pins.host_data_oe      = h_reg.data_oe;
  assign reg_rdata              = h_reg.rdata;
endmodule

/* File: adc_par_sva.sv */
// pin-level checks between the converter end and the host end
module adc_par_sva (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic host_data_oe,
  input wire logic dev_data_oe,
  input wire logic dev_done_n,
  input wire logic dev_done_oe
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  // ****************************************
  // strobe events as the converter takes them
  // ****************************************
  sequence read_fall_s;
    !cs_n && $fell(rd_n);
  endsequence
  sequence write_rise_s;
    !cs_n && $rose(wr_n);
  endsequence
  // ****************************************
  // assertions
  // ****************************************
  float_deselect_a: assert property (
    cs_n |=> !dev_data_oe && !dev_done_oe) else $error("outputs driven while deselected");
  done_driven_a: assert property (
    !cs_n |=> dev_done_oe) else $error("done line not driven while selected");
  read_drive_a: assert property (
    read_fall_s |=> dev_data_oe) else $error("read fall did not drive data");
  read_clear_a: assert property (
    read_fall_s ##0 !dev_done_n |=> dev_done_n) else $error("done not cleared by read");
  write_clear_a: assert property (
    write_rise_s |=> dev_done_n) else $error("done not cleared by write");
  done_hold_a: assert property (
    !dev_done_n && !(!cs_n && ($fell(rd_n) || $rose(wr_n))) |=> !dev_done_n)
    else $error("done released without read or write");
  strobe_select_a: assert property (
    !wr_n || !rd_n |-> !cs_n) else $error("strobe without select");
  strobe_excl_a: assert property (
    !(!wr_n && !rd_n)) else $error("read and write strobes together");
  no_clash_a: assert property (
    !(dev_data_oe && host_data_oe)) else $error("both ends drive data lines");
  wr_pulse_a: assert property (
    $fell(wr_n) |-> !wr_n [*8]) else $error("write strobe too short");
endmodule

/* File: tb.sv */
// self-checking bench joining the converter end and the host end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TDIV = 8;
  logic        ref_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        comparator_high = 1'b0;
  logic        track;
  logic        hold_to_negative;
  logic        neg_is_common;
  logic        unipolar;
  logic        done_raw;
  logic        up_q = 1'b0;
  logic        oe_q = 1'b0;
  logic [2:0]  pos_channel;
  logic [2:0]  neg_channel;
  logic [9:0]  dac_code;
  logic [9:0]  sample = 10'h0;
  logic [9:0]  exp_res = 10'h0;
  logic [31:0] rd_val;
  integer      err_total = 0;
  integer      comparisons = 0;
  integer      seed = 5199;
  integer      n;
  always #2 ref_clk = ~ref_clk;
  // comparator of the held sample against the trial code
  always @(posedge ref_clk) comparator_high <= (sample >= dac_code);
  assign done_raw = adc_par_if_i.dev_done_n;
  adc_par_if adc_par_if_i ();
  adc_par_dev #(.NUM_CH(8), .TICK_DIV(TDIV)) adc_par_dev_i (
    .ref_clk(ref_clk), .rstn(rstn), .pins(adc_par_if_i), .comparator_high(comparator_high),
    .track(track), .hold_to_negative(hold_to_negative), .pos_channel(pos_channel),
    .neg_channel(neg_channel), .neg_is_common(neg_is_common), .unipolar(unipolar),
    .dac_code(dac_code));
  adc_par_host #(.EXT_CLK_HALF(TDIV / 2)) adc_par_host_i (
    .ref_clk(ref_clk), .rstn(rstn), .pins(adc_par_if_i), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  adc_par_sva adc_par_sva_i (
    .ref_clk(ref_clk), .rstn(rstn), .cs_n(adc_par_if_i.cs_n), .wr_n(adc_par_if_i.wr_n),
    .rd_n(adc_par_if_i.rd_n), .host_data_oe(adc_par_if_i.host_data_oe),
    .dev_data_oe(adc_par_if_i.dev_data_oe), .dev_done_n(adc_par_if_i.dev_done_n),
    .dev_done_oe(adc_par_if_i.dev_done_oe));
  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("comparisons=%0d mismatches=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  function automatic logic [9:0] sar_expect(input logic [9:0] s);
    logic [9:0] r;
    r = 10'h0;
    for (int b = 9; b >= 0; b--) begin
      r[b] = 1'b1;
      if (!(s >= r)) r[b] = 1'b0;
    end
    return r;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask
  // bounded waits; a run-out counts as a mismatch
  task automatic idle_wait();
    for (n = 0; n < 200; n++) begin
      rd(adc_par_pkg::REG_STATUS);
      if (rd_val[0] === 1'b0) break;
    end
    if (n == 200) check(32'h0, 32'h1);
  endtask
  task automatic wait_until(ref logic s, input logic v);
    for (n = 1; n < 2000; n++) begin
      @(posedge ref_clk);
      #1;
      if (s === v) break;
    end
    if (n == 2000) check(32'h0, 32'h1);
  endtask
  task automatic read_check(input logic [9:0] s);
    exp_res = sar_expect(s);
    wr(adc_par_pkg::REG_READ_START, 32'h0);
    idle_wait();
    rd(adc_par_pkg::REG_RESULT);
    check(rd_val, {22'h0, exp_res});
    check(done_raw, 1'b1);
  endtask
  task automatic conv(input logic [7:0] c, input logic [9:0] s);
    sample = s;
    wr(adc_par_pkg::REG_CTRL_WRITE, {24'h0, c});
    // up to the cycle the converter takes the write; an external start may tick at once
    repeat (adc_par_pkg::CS_SETUP_CYC + adc_par_pkg::WR_PULSE_CYC + 2) @(posedge ref_clk);
    wait_until(hold_to_negative, 1'b1);
    check(pos_channel, c[2:0]);
    check(neg_is_common, c[3]);
    if (!c[3]) check(neg_channel, c[2:0] ^ 3'h1);
    check(unipolar, c[4]);
    if (c[7:6] != 2'b11) check(adc_par_if_i.conv_clk, 1'b0);
    check(track, 1'b0);
    check(dac_code, 10'h200);
    wait_until(done_raw, 1'b0);
    // first conversion tick to the thirteenth: twelve tick periods
    check(n, 12 * TDIV);
    idle_wait();
    read_check(s);
  endtask
  // ****************************************
  // data lines seen on the wire during reads
  // ****************************************
  always @(posedge ref_clk) begin
    up_q <= adc_par_if_i.upper_byte_select;
    oe_q <= adc_par_if_i.dev_data_oe;
    if (oe_q && adc_par_if_i.dev_data_oe && up_q == adc_par_if_i.upper_byte_select) begin
      if (up_q) check(adc_par_if_i.data_bus_lines[1:0], exp_res[9:8]);
      else check(adc_par_if_i.data_bus_lines, exp_res[7:0]);
    end
  end
  initial begin
    #100000;
    err_total++;
    summarize();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    conv(8'h98, 10'h000);
    conv(8'h87, 10'h3ff);
    repeat (6) conv({3'b100, 5'($random(seed))}, 10'($random(seed)));
    // write in mid-conversion restarts; result kept for a second read
    wr(adc_par_pkg::REG_CTRL_WRITE, 32'h9a);
    idle_wait();
    wait_until(hold_to_negative, 1'b1);
    conv(8'h9a, 10'h155);
    read_check(10'h155);
    // external clock and external acquisition
    wr(adc_par_pkg::REG_CLK_CFG, 32'h1);
    rd(adc_par_pkg::REG_CLK_CFG);
    check(rd_val, 32'h1);
    wr(adc_par_pkg::REG_CTRL_WRITE, 32'he9);
    idle_wait();
    repeat (50) @(posedge ref_clk);
    check(track, 1'b1);
    check(hold_to_negative, 1'b0);
    conv(8'hc9, 10'h2a7);
    rd(8'h20);
    check(rd_val, 32'h0);
    summarize();
  end
endmodule
